// File: test/i2c_ctrl_model.sv
// two-wire bus controller model that drives the serial clock and data line
`timescale 1ns/1ps
module i2c_ctrl_model (
  // two-wire link
  output logic o_scl,
  output logic o_sda_oe,
  input wire logic i_sda
);
  // ****************
  // line control
  // ****************
  // clock stands high and data is released between frames
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end

  // start or repeated start: data falls while clock is high
  task automatic start_cond();
    if (o_scl == 1'b0) begin
      o_sda_oe = 1'b0;
      #12;
      o_scl = 1'b1;
      #12;
    end
    o_sda_oe = 1'b1;
    #12;
    o_scl = 1'b0;
    #12;
  endtask

  // one bit: data set while clock low, line sampled mid-high
  task automatic put_bit(input logic b, output logic r);
    o_sda_oe = ~b;
    #12;
    o_scl = 1'b1;
    #12;
    r = i_sda;
    #12;
    o_scl = 1'b0;
    #12;
  endtask

  // a byte msb first, then the acknowledge slot on the ninth clock
  task automatic xfer(input logic [7:0] d, input logic ack_b, output logic [7:0] r, output logic ack_seen);
    logic b;
    for (int k = 7; k >= 0; k--) begin
      put_bit(d[k], b);
      r[k] = b;
    end
    put_bit(ack_b, ack_seen);
  endtask

  // stop: data rises while clock is high, clock then stands still
  task automatic stop_cond();
    o_sda_oe = 1'b1;
    #12;
    o_scl = 1'b1;
    #12;
    o_sda_oe = 1'b0;
    #24;
  endtask
endmodule

// File: test/tb_serial_eeprom_read_engine.sv
// self-checking bench of the serial memory read engine
`timescale 1ns/1ps
module tb_serial_eeprom_read_engine;
  import eeprom_rd_pkg::*;
  // ****************
  // signals
  // ****************
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_fill_valid = 1'b0;
  logic [ADDR_W-1:0] i_fill_addr = '0;
  logic [7:0] i_fill_data = '0;
  logic [2:0] cs = '0;
  logic o_busy, o_sda, o_sda_oe, scl, ctrl_oe;
  logic [ADDR_W-1:0] o_addr_count;
  wire logic sda;
  logic [7:0] mem [logic [15:0]];
  logic [15:0] exp_cnt = '0;
  logic [15:0] base;
  integer seed = 32'hE7E78266;
  int fails = 0;
  int checks = 0;

  // open-drain line: low if anyone pulls, else the pull-up wins
  assign sda = ~ctrl_oe & (o_sda_oe ? o_sda : 1'b1);

  // 40 MHz system clock
  always #12.5 i_clk = ~i_clk;

  serial_eeprom_read_engine u_dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_fill_valid(i_fill_valid), .i_fill_addr(i_fill_addr), .i_fill_data(i_fill_data),
    .o_busy(o_busy), .o_addr_count(o_addr_count),
    .i_scl(scl), .i_sda(sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
    .i_chip_select_bit_high(cs[2]), .i_chip_select_bit_mid(cs[1]), .i_chip_select_bit_low(cs[0])
  );

  i2c_ctrl_model u_ctrl (.o_scl(scl), .o_sda_oe(ctrl_oe), .i_sda(sda));

  // ****************
  // checking
  // ****************
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************
  // stimulus
  // ****************
  // random bytes into the store, mirrored in the bench copy
  task automatic fill(input logic [15:0] a, input int n);
    logic [7:0] d;
    for (int k = 0; k < n; k++) begin
      @(posedge i_clk);
      d = 8'($random(seed));
      i_fill_valid <= 1'b1;
      i_fill_addr <= a + k[15:0];
      i_fill_data <= d;
      mem[a + k[15:0]] = d;
    end
    @(posedge i_clk);
    i_fill_valid <= 1'b0;
  endtask

  task automatic dev_byte(input logic [7:0] dev, input logic acked);
    logic [7:0] r;
    logic a;
    u_ctrl.start_cond();
    u_ctrl.xfer(dev, 1'b1, r, a);
    cmp_bit("device_ack", ~acked, a);
  endtask

  // dummy write that loads the counter with a two-byte address
  task automatic dummy_write(input logic [15:0] t);
    logic [7:0] r;
    logic a;
    dev_byte({DEV_TYPE, cs, 1'b0}, 1'b1);
    u_ctrl.xfer(t[15:8], 1'b1, r, a);
    cmp_bit("addr_hi_ack", 1'b0, a);
    u_ctrl.xfer(t[7:0], 1'b1, r, a);
    cmp_bit("addr_lo_ack", 1'b0, a);
    exp_cnt = t;
  endtask

  // current-address read of n bytes, last one left unacknowledged
  task automatic cur_read(input int n);
    logic [7:0] r;
    logic a;
    dev_byte({DEV_TYPE, cs, 1'b1}, 1'b1);
    @(negedge i_clk);
    cmp_bit("busy_in_frame", 1'b1, o_busy);
    for (int k = 0; k < n; k++) begin
      u_ctrl.xfer(8'hFF, k == n - 1, r, a);
      cmp_word("read_byte", {8'h00, mem[exp_cnt]}, {8'h00, r});
      exp_cnt = exp_cnt + 16'h0001;
    end
    u_ctrl.stop_cond();
    repeat (10) @(negedge i_clk);
    cmp_bit("busy_after_stop", 1'b0, o_busy);
    cmp_word("addr_count", exp_cnt, o_addr_count);
  endtask

  // main sequence: random straps, reset, fill, then the read modes
  initial begin
    logic [7:0] r;
    logic a;
    cs = 3'($random(seed));
    @(negedge i_clk);
    cmp_bit("sda_oe_rst", 1'b0, o_sda_oe);
    cmp_bit("busy_rst", 1'b0, o_busy);
    cmp_word("addr_count_rst", 16'h0000, o_addr_count);
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    base = 16'($random(seed));
    fill(base, 8);
    fill(16'hFFFC, 8);
    repeat (4) @(posedge i_clk);
    dummy_write(base);
    cur_read(3);
    cur_read(1);
    dummy_write(16'hFFFE);
    cur_read(4);
    // wrong type code, then each select bit wrong: no acknowledge
    for (int k = 0; k < 4; k++) begin
      dev_byte(k == 0 ? {DEV_TYPE ^ 4'h8, cs, 1'b1} : {DEV_TYPE, cs ^ (3'h1 << (k - 1)), 1'b1}, 1'b0);
      u_ctrl.stop_cond();
    end
    // data byte after the dummy write is refused but the load holds
    dummy_write(base + 16'h0002);
    u_ctrl.xfer(8'h5A, 1'b1, r, a);
    cmp_bit("data_ack", 1'b1, a);
    u_ctrl.stop_cond();
    cur_read(2);
    finish_test();
  end

  // watchdog: the whole sequence needs well under 40 us
  initial begin
    #200000;
    fails++;
    finish_test();
  end
endmodule

// File: verilog/eeprom_rd_pkg.sv
// constants and carrier types of the serial memory read engine
package eeprom_rd_pkg;

  // ****************************************
  // sizes and codes
  // ****************************************
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned MEM_DEPTH = 65536;
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] STALE_BYTE = 8'hFF;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] ADDR_STEP = 16'h0001;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [9:0] {
    S_IDLE   = 10'h001,
    S_DEV    = 10'h002,
    S_DEVACK = 10'h004,
    S_AHI    = 10'h008,
    S_AHIACK = 10'h010,
    S_ALO    = 10'h020,
    S_ALOACK = 10'h040,
    S_WDATA  = 10'h080,
    S_TX     = 10'h100,
    S_TXACK  = 10'h200
  } link_st_t;

  typedef struct packed {
    logic load;
    logic [15:0] addr;
  } cmd_t;

  typedef struct packed {
    logic sda;
    logic [7:0] rx;
  } rise_t;

  typedef struct packed {
    link_st_t st;
    logic [2:0] cnt;
    logic oe;
    logic [7:0] tx;
    logic rw;
    logic [7:0] ahi;
    cmd_t cmd;
    logic req;
    logic stop_ref;
  } fall_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic ack;
    logic busy;
  } core_t;

endpackage

// File: verilog/serial_eeprom_read_engine.sv
// read path of a two-wire serial memory target with its byte store
`timescale 1ns/1ps
module serial_eeprom_read_engine
  import eeprom_rd_pkg::*;
(
  // system clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // byte store fill port and status
  input wire logic i_fill_valid,
  input wire logic [ADDR_W-1:0] i_fill_addr,
  input wire logic [7:0] i_fill_data,
  output logic o_busy,
  output logic [ADDR_W-1:0] o_addr_count,
  // two-wire link
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // chip select straps
  input wire logic i_chip_select_bit_high,
  input wire logic i_chip_select_bit_mid,
  input wire logic i_chip_select_bit_low
);

  // ****************************************
  // declarations
  // ****************************************
  logic [7:0] mem [0:MEM_DEPTH-1];
  core_t core_q;
  core_t core_d;
  rise_t rise_q;
  rise_t rise_d;
  fall_t fall_q;
  fall_t fall_d;
  logic req_s;
  logic busy_s;
  logic ack_s;
  logic [2:0] cs_s;
  logic [15:0] addr_inc;
  logic start_ev;
  logic stop_ev;
  logic dev_hit;
  logic ready;
  logic tx_go;
  logic [7:0] next_tx;
  logic stop_tgl_q;
  logic stop_seen;

  // ****************************************
  // crossings
  // ****************************************
  sync3 #(.WIDTH(1)) u_req_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_d(fall_q.req),
    .o_q(req_s)
  );

  // idle bit of the one-hot state is a single flop, safe to cross
  sync3 #(.WIDTH(1)) u_busy_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_d(~fall_q.st[0]),
    .o_q(busy_s)
  );

  sync3 #(.WIDTH(1)) u_ack_sync (
    .i_clk(i_scl),
    .i_rst_b(i_rst_b),
    .i_d(core_q.ack),
    .o_q(ack_s)
  );

  // straps are static, but they still come from pins
  sync3 #(.WIDTH(3)) u_cs_sync (
    .i_clk(i_scl),
    .i_rst_b(i_rst_b),
    .i_d({i_chip_select_bit_high, i_chip_select_bit_mid, i_chip_select_bit_low}),
    .o_q(cs_s)
  );

  // ****************************************
  // byte store and address counter (system clock)
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_fill_valid) begin
      mem[i_fill_addr] <= i_fill_data;
    end
  end

  // 16-bit add wraps from the top location to zero by itself
  assign addr_inc = core_q.addr + ADDR_STEP;

  // a command is held stable by the link until its toggle is answered
  always_comb begin
    core_d = core_q;
    core_d.busy = busy_s;
    if (req_s != core_q.ack) begin
      core_d.ack = req_s;
      if (fall_q.cmd.load) begin
        core_d.addr = fall_q.cmd.addr;
        core_d.data = mem[fall_q.cmd.addr];
      end else begin
        core_d.addr = addr_inc;
        core_d.data = mem[addr_inc];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      core_q <= '{addr: ADDR_RST, data: DATA_RST, ack: 1'b0, busy: 1'b0};
    end else begin
      core_q <= core_d;
    end
  end

  // ****************************************
  // link: rising edge captures
  // ****************************************
  always_comb begin
    rise_d.sda = i_sda;
    rise_d.rx = {rise_q.rx[6:0], i_sda};
  end

  always_ff @(posedge i_scl or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rise_q <= '{sda: 1'b1, rx: 8'h00};
    end else begin
      rise_q <= rise_d;
    end
  end

  // ****************************************
  // link: falling edge runs the sequence
  // ****************************************
  // a stop followed by a start within one high phase leaves equal rise and fall
  // samples, so a rising data edge with the clock high is marked by a toggle
  always_ff @(posedge i_sda or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stop_tgl_q <= 1'b0;
    end else if (i_scl) begin
      stop_tgl_q <= ~stop_tgl_q;
    end
  end

  assign stop_seen = (stop_tgl_q != fall_q.stop_ref);
  // a level that differs between rise and fall moved while the clock was high
  assign start_ev = (rise_q.sda | stop_seen) & ~i_sda;
  assign stop_ev = (~rise_q.sda | stop_seen) & i_sda;
  assign dev_hit = (rise_q.rx[7:4] == DEV_TYPE) && (rise_q.rx[3:1] == cs_s);
  assign ready = (ack_s == fall_q.req);
  // a byte not yet answered by the store goes out as all ones
  assign next_tx = ready ? core_q.data : STALE_BYTE;

  always_comb begin
    fall_d = fall_q;
    fall_d.stop_ref = stop_tgl_q;
    tx_go = 1'b0;
    fall_d.cnt = fall_q.cnt + 3'h1;
    if (start_ev) begin
      fall_d.st = S_DEV;
      fall_d.cnt = 3'h0;
      fall_d.oe = 1'b0;
    end else if (stop_ev) begin
      fall_d.st = S_IDLE;
      fall_d.oe = 1'b0;
    end else begin
      unique case (fall_q.st)
        S_IDLE: begin
          fall_d.cnt = 3'h0;
        end
        S_DEV: begin
          if (fall_q.cnt == BIT_LAST) begin
            fall_d.rw = rise_q.rx[0];
            fall_d.st = dev_hit ? S_DEVACK : S_IDLE;
            fall_d.oe = dev_hit;
          end
        end
        S_DEVACK: begin
          fall_d.oe = 1'b0;
          fall_d.cnt = 3'h0;
          if (fall_q.rw) begin
            tx_go = 1'b1;
          end else begin
            fall_d.st = S_AHI;
          end
        end
        S_AHI: begin
          if (fall_q.cnt == BIT_LAST) begin
            fall_d.ahi = rise_q.rx;
            fall_d.st = S_AHIACK;
            fall_d.oe = 1'b1;
          end
        end
        S_AHIACK: begin
          fall_d.oe = 1'b0;
          fall_d.cnt = 3'h0;
          fall_d.st = S_ALO;
        end
        S_ALO: begin
          if (fall_q.cnt == BIT_LAST) begin
            fall_d.st = S_ALOACK;
            fall_d.oe = 1'b1;
            if (ready) begin
              fall_d.cmd = '{load: 1'b1, addr: {fall_q.ahi, rise_q.rx}};
              fall_d.req = ~fall_q.req;
            end
          end
        end
        S_ALOACK: begin
          fall_d.oe = 1'b0;
          fall_d.cnt = 3'h0;
          fall_d.st = S_WDATA;
        end
        S_WDATA: begin
          // no write path: a data byte here is left unacknowledged
          if (fall_q.cnt == BIT_LAST) begin
            fall_d.st = S_IDLE;
          end
        end
        S_TX: begin
          if (fall_q.cnt == BIT_LAST) begin
            fall_d.oe = 1'b0;
            fall_d.st = S_TXACK;
          end else begin
            fall_d.tx = {fall_q.tx[6:0], 1'b0};
            fall_d.oe = ~fall_q.tx[6];
          end
        end
        S_TXACK: begin
          if (!rise_q.sda) begin
            tx_go = 1'b1;
          end else begin
            fall_d.st = S_IDLE;
          end
        end
        default: begin
          fall_d.st = S_IDLE;
          fall_d.oe = 1'b0;
        end
      endcase
    end
    // load the next byte, drive its msb and, if the store is ready, ask it to advance
    if (tx_go) begin
      fall_d.st = S_TX;
      fall_d.cnt = 3'h0;
      fall_d.tx = next_tx;
      fall_d.oe = ~next_tx[7];
      if (ready) begin
        fall_d.cmd.load = 1'b0;
        fall_d.req = ~fall_q.req;
      end
    end
  end

  always_ff @(negedge i_scl or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fall_q <= '{st: S_IDLE, cnt: 3'h0, oe: 1'b0, tx: 8'h00, rw: 1'b0, ahi: 8'h00,
                  cmd: '{load: 1'b0, addr: ADDR_RST}, req: 1'b0, stop_ref: 1'b0};
    end else begin
      fall_q <= fall_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_sda = 1'b0; // open drain: only ever pulls low
  assign o_sda_oe = fall_q.oe;
  assign o_busy = core_q.busy;
  assign o_addr_count = core_q.addr;

  // ****************************************
  // checks
  // ****************************************
  a_dev_ack_hit: assert property (@(negedge i_scl) disable iff (!i_rst_b)
    (fall_q.st == S_DEV && fall_q.cnt == BIT_LAST && dev_hit && !start_ev && !stop_ev)
      |=> (fall_q.st == S_DEVACK && fall_q.oe))
    else $error("matching device byte not acknowledged");
  a_dev_miss_idle: assert property (@(negedge i_scl) disable iff (!i_rst_b)
    (fall_q.st == S_DEV && fall_q.cnt == BIT_LAST && !dev_hit && !start_ev && !stop_ev)
      |=> (fall_q.st == S_IDLE && !fall_q.oe))
    else $error("foreign device byte acknowledged");
  a_read_dir_tx: assert property (@(negedge i_scl) disable iff (!i_rst_b)
    (fall_q.st == S_DEVACK && fall_q.rw && !start_ev && !stop_ev)
      |=> (fall_q.st == S_TX && fall_q.cnt == 3'h0))
    else $error("read direction did not start data");
  a_release_ack_slot: assert property (@(negedge i_scl) disable iff (!i_rst_b)
    (fall_q.st == S_TXACK) |-> !fall_q.oe)
    else $error("data line driven in controller slot");
  a_nack_goes_idle: assert property (@(negedge i_scl) disable iff (!i_rst_b)
    (fall_q.st == S_TXACK && rise_q.sda && !start_ev && !stop_ev) |=> fall_q.st == S_IDLE)
    else $error("no acknowledge but still sending");
  a_ack_next_byte: assert property (@(negedge i_scl) disable iff (!i_rst_b)
    (fall_q.st == S_TXACK && !rise_q.sda && !start_ev && !stop_ev)
      |=> (fall_q.st == S_TX) ##1 (fall_q.st == S_TX)[*7] ##1 (fall_q.st == S_TXACK))
    else $error("acknowledge did not yield one byte");
  a_stop_idle: assert property (@(negedge i_scl) disable iff (!i_rst_b)
    (stop_ev && !start_ev) |=> (fall_q.st == S_IDLE && !fall_q.oe))
    else $error("stop did not return to idle");
  a_start_restarts: assert property (@(negedge i_scl) disable iff (!i_rst_b)
    start_ev |=> (fall_q.st == S_DEV && fall_q.cnt == 3'h0 && !fall_q.oe))
    else $error("start did not open a device byte");
  a_load_counter: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (req_s != core_q.ack && fall_q.cmd.load) |=> (core_q.addr == $past(fall_q.cmd.addr)))
    else $error("address load not taken");
  a_advance_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (req_s != core_q.ack && !fall_q.cmd.load) |=> (core_q.addr == 16'($past(core_q.addr) + 16'h0001)))
    else $error("counter did not advance by one");

  c_single_read: cover property (@(negedge i_scl) disable iff (!i_rst_b)
    fall_q.st == S_TXACK && rise_q.sda);
  c_seq_read: cover property (@(negedge i_scl) disable iff (!i_rst_b)
    fall_q.st == S_TXACK && !rise_q.sda && !start_ev);
  c_dummy_write_restart: cover property (@(negedge i_scl) disable iff (!i_rst_b)
    fall_q.st == S_WDATA && start_ev);
  c_wrap: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    req_s != core_q.ack && !fall_q.cmd.load && core_q.addr == 16'hFFFF);

endmodule

// File: verilog/sync3.sv
// three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/1ps
module sync3 #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // data
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sync_t;

  sync_t sy_q;
  sync_t sy_d;

  // first stage feeds only the second; output moves when later stages agree
  always_comb begin
    sy_d = sy_q;
    sy_d.s1 = i_d;
    sy_d.s2 = sy_q.s1;
    sy_d.s3 = sy_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (sy_q.s2[i] == sy_q.s3[i]) begin
        sy_d.q[i] = sy_q.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sy_q <= '0;
    end else begin
      sy_q <= sy_d;
    end
  end

  assign o_q = sy_q.q;

endmodule
